//--- lcdps_defs.svh
// Register offsets, field positions and reset values for the geometry and power save slice
`ifndef LCDPS_DEFS_SVH
`define LCDPS_DEFS_SVH
`define OFF_FRAME_HEIGHT   8'h05
`define OFF_HRANGE_LOW     8'h06
`define OFF_HRANGE_HIGH    8'h07
`define OFF_POWER_SAVE     8'h08
`define OFF_DISPLAY_ONOFF  8'h09
`define BIT_PS_ENABLE      0
`define BIT_DISP_ENABLE    0
`define RST_POWER_SAVE     8'h01
`define RST_DISPLAY_ONOFF  8'h00
`define RST_FRAME_HEIGHT   8'h00
`define RST_HRANGE         16'h0000
`define CMD_SYSTEM_SET     8'h40
`define CMD_POWER_DOWN     8'h53
`endif

//--- lcdps_pkg.sv
// Types for the geometry and power save register slice
package lcdps_pkg;
    typedef enum logic [2:0] {
        ST_RUN    = 3'b001,
        ST_SAVE   = 3'b010,
        ST_WAKE   = 3'b100
    } pwr_state_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       cmd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_type;

    typedef struct packed {
        logic [7:0]  frame_height;
        logic [15:0] hrange;
        logic        disp_en;
    } geom_type;
endpackage

//--- lcdps_regs.sv
// Frame geometry and software power save register slice
`timescale 1ns/1ps
`include "lcdps_defs.svh"

module lcdps_regs (
    input  wire logic                  MCLK,       // System clock, 50 MHz
    input  wire logic                  RST,        // Synchronous reset, high
    input  wire lcdps_pkg::host_req_type REQ,      // Host access, one cycle per strobe
    output logic [7:0]                 RDATA,      // Read data
    output logic                       OSC_RUN,    // Oscillator and internal operation run
    output logic                       PANEL_ON,   // Panel output enabled
    output lcdps_pkg::geom_type        GEOM        // Geometry to display control
);
    import lcdps_pkg::*;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Bits picked out of the byte-wide reset constants
    localparam logic [7:0] ps_reset       = `RST_POWER_SAVE;
    localparam logic [7:0] disp_reset     = `RST_DISPLAY_ONOFF;
    localparam logic       ps_reset_bit   = ps_reset[`BIT_PS_ENABLE];
    localparam logic       disp_reset_bit = disp_reset[`BIT_DISP_ENABLE];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pwr_state_type pst;
        logic        ps_en;
        logic [7:0]  frame_height;
        logic [15:0] hrange;
        logic        disp_en;
        logic [7:0]  rdata;
        logic        osc_run;
        logic        panel_on;
    } state_type;

    state_type s_q;
    state_type s_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (REQ.wr && !REQ.cmd) begin
            if (hit(REQ.addr, `OFF_FRAME_HEIGHT)) begin
                s_d.frame_height = REQ.wdata;
            end
            if (hit(REQ.addr, `OFF_HRANGE_LOW)) begin
                s_d.hrange[7:0] = REQ.wdata;
            end
            if (hit(REQ.addr, `OFF_HRANGE_HIGH)) begin
                s_d.hrange[15:8] = REQ.wdata;
            end
            if (hit(REQ.addr, `OFF_DISPLAY_ONOFF)) begin
                s_d.disp_en = REQ.wdata[`BIT_DISP_ENABLE];
            end
            if (hit(REQ.addr, `OFF_POWER_SAVE)) begin
                s_d.ps_en = REQ.wdata[`BIT_PS_ENABLE];
            end
        end
        if (REQ.wr && REQ.cmd) begin
            if (REQ.wdata == `CMD_POWER_DOWN) begin
                s_d.ps_en = 1'b1;
            end
            if (REQ.wdata == `CMD_SYSTEM_SET) begin
                s_d.ps_en = 1'b0;
            end
        end
        unique case (s_q.pst)
            ST_RUN: begin
                if (s_d.ps_en) begin
                    s_d.pst = ST_SAVE;
                end
            end
            ST_SAVE: begin
                if (!s_d.ps_en) begin
                    // Direct exit waits for a dummy write; command exit is immediate
                    s_d.pst = ST_WAKE;
                end
                if (REQ.wr && REQ.cmd && REQ.wdata == `CMD_SYSTEM_SET) begin
                    s_d.pst = ST_RUN;
                end
            end
            ST_WAKE: begin
                if (s_d.ps_en) begin
                    s_d.pst = ST_SAVE;
                end else if (REQ.wr) begin
                    s_d.pst = ST_RUN;
                end
            end
        endcase
        if (s_d.ps_en) begin
            s_d.disp_en = 1'b0;
        end
        s_d.osc_run  = (s_d.pst == ST_RUN);
        s_d.panel_on = s_d.disp_en && (s_d.pst == ST_RUN);
        s_d.rdata    = 8'h00;
        if (REQ.rd) begin
            if (hit(REQ.addr, `OFF_FRAME_HEIGHT)) begin
                s_d.rdata = s_q.frame_height;
            end else if (hit(REQ.addr, `OFF_HRANGE_LOW)) begin
                s_d.rdata = s_q.hrange[7:0];
            end else if (hit(REQ.addr, `OFF_HRANGE_HIGH)) begin
                s_d.rdata = s_q.hrange[15:8];
            end else if (hit(REQ.addr, `OFF_POWER_SAVE)) begin
                s_d.rdata = {7'h00, s_q.ps_en};
            end else if (hit(REQ.addr, `OFF_DISPLAY_ONOFF)) begin
                s_d.rdata = {7'h00, s_q.disp_en};
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RST) begin
            s_q.pst          <= ST_SAVE;
            s_q.ps_en        <= ps_reset_bit;
            s_q.frame_height <= `RST_FRAME_HEIGHT;
            s_q.hrange       <= `RST_HRANGE;
            s_q.disp_en      <= disp_reset_bit;
            s_q.rdata        <= 8'h00;
            s_q.osc_run      <= 1'b0;
            s_q.panel_on     <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign RDATA    = s_q.rdata;
    assign OSC_RUN  = s_q.osc_run;
    assign PANEL_ON = s_q.panel_on;
    assign GEOM     = '{frame_height: s_q.frame_height, hrange: s_q.hrange,
                        disp_en: s_q.disp_en};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    pd_cmd_enters_a: assert property (@(posedge MCLK) disable iff (RST)
        REQ.wr && REQ.cmd && REQ.wdata == `CMD_POWER_DOWN |=> !OSC_RUN)
        else $error("power-down command did not stop operation");
    sys_cmd_exits_a: assert property (@(posedge MCLK) disable iff (RST)
        REQ.wr && REQ.cmd && REQ.wdata == `CMD_SYSTEM_SET |=> OSC_RUN)
        else $error("system setup command did not resume operation");
    ps_bit_write_a: assert property (@(posedge MCLK) disable iff (RST)
        REQ.wr && !REQ.cmd && REQ.addr == `OFF_POWER_SAVE |=> s_q.ps_en == $past(REQ.wdata[0]))
        else $error("power save bit not written");
    halt_in_save_a: assert property (@(posedge MCLK) disable iff (RST)
        s_q.ps_en |-> !OSC_RUN)
        else $error("running while power save enabled");
    dummy_wake_a: assert property (@(posedge MCLK) disable iff (RST)
        s_q.pst == ST_WAKE && REQ.wr && !s_d.ps_en |=> OSC_RUN)
        else $error("dummy write did not finish exit");
    disp_clear_a: assert property (@(posedge MCLK) disable iff (RST)
        $rose(s_q.ps_en) |-> !s_q.disp_en && !PANEL_ON)
        else $error("display enable not cleared on power save");
    panel_gate_a: assert property (@(posedge MCLK) disable iff (RST)
        PANEL_ON |-> s_q.disp_en && OSC_RUN)
        else $error("panel on without display enable");
    normal_run_a: assert property (@(posedge MCLK) disable iff (RST)
        s_q.pst == ST_RUN |-> !s_q.ps_en)
        else $error("normal state with power save set");

    // Antecedents sample the request or the registered state, consequents the registered state
    ps_readback_a: assert property (@(posedge MCLK) disable iff (RST)
        REQ.rd && REQ.addr == `OFF_POWER_SAVE |=> RDATA == {7'h00, $past(s_q.ps_en)})
        else $error("power save bit read back wrong");
    save_state_a: assert property (@(posedge MCLK) disable iff (RST)
        s_q.ps_en |-> s_q.pst == ST_SAVE)
        else $error("power save set outside the halted state");
    save_disp_low_a: assert property (@(posedge MCLK) disable iff (RST)
        s_q.ps_en |-> !s_q.disp_en)
        else $error("display enable set during power save");
    panel_off_a: assert property (@(posedge MCLK) disable iff (RST)
        !s_q.disp_en |-> !PANEL_ON)
        else $error("panel on with display enable clear");
    pd_clears_disp_a: assert property (@(posedge MCLK) disable iff (RST)
        REQ.wr && REQ.cmd && REQ.wdata == `CMD_POWER_DOWN |=> !s_q.disp_en)
        else $error("power-down command left display enable set");
    direct_enter_a: assert property (@(posedge MCLK) disable iff (RST)
        REQ.wr && !REQ.cmd && REQ.addr == `OFF_POWER_SAVE && REQ.wdata[0] |=> !OSC_RUN)
        else $error("power save bit write did not halt operation");
    stay_halted_a: assert property (@(posedge MCLK) disable iff (RST)
        s_q.ps_en && !(REQ.wr && REQ.cmd && REQ.wdata == `CMD_SYSTEM_SET) |=> !OSC_RUN)
        else $error("operation resumed while power save enabled");
    wake_first_a: assert property (@(posedge MCLK) disable iff (RST)
        s_q.pst == ST_SAVE && REQ.wr && !REQ.cmd && REQ.addr == `OFF_POWER_SAVE
        && !REQ.wdata[0] |=> s_q.pst == ST_WAKE && !OSC_RUN)
        else $error("clearing power save bit did not await dummy write");
    sys_clears_a: assert property (@(posedge MCLK) disable iff (RST)
        REQ.wr && REQ.cmd && REQ.wdata == `CMD_SYSTEM_SET |=> !s_q.ps_en)
        else $error("system setup command left power save set");
    pd_sets_a: assert property (@(posedge MCLK) disable iff (RST)
        REQ.wr && REQ.cmd && REQ.wdata == `CMD_POWER_DOWN |=> s_q.ps_en)
        else $error("power-down command did not set power save");
    disp_write_a: assert property (@(posedge MCLK) disable iff (RST)
        REQ.wr && !REQ.cmd && REQ.addr == `OFF_DISPLAY_ONOFF && REQ.wdata[0]
        && s_q.pst == ST_RUN |=> PANEL_ON)
        else $error("display enable write did not turn panel on");
    run_persists_a: assert property (@(posedge MCLK) disable iff (RST)
        s_q.pst == ST_RUN && !REQ.wr |=> OSC_RUN)
        else $error("normal operation stopped without a write");
endmodule // lcdps_regs

//--- lcdps_host.sv
// Host processor model driving the register slice access strobes
`timescale 1ns/1ps

module lcdps_host (
    input  wire logic               MCLK,  // System clock
    output lcdps_pkg::host_req_type REQ,   // Access strobes to the slice
    input  wire logic [7:0]         RDATA  // Read data from the slice
);
    import lcdps_pkg::*;

    initial REQ = '0;

    // One strobe cycle per access, released after the taking edge
    task automatic wr(input logic c, input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        REQ <= '{wr: 1'b1, rd: 1'b0, cmd: c, addr: a, wdata: d};
        @(posedge MCLK);
        REQ <= '0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK);
        REQ <= '{wr: 1'b0, rd: 1'b1, cmd: 1'b0, addr: a, wdata: 8'h00};
        @(posedge MCLK);
        REQ <= '0;
        #1;
        d = RDATA;
    endtask
endmodule // lcdps_host

//--- tb_lcdps_regs.sv
// Self-checking bench for the geometry and power save register slice
`timescale 1ns/1ps
`include "lcdps_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end

module tb_lcdps_regs;
    import lcdps_pkg::*;
    logic         MCLK = 1'b0;
    logic         RST  = 1'b1;
    host_req_type req;
    logic [7:0]   rdata;
    logic [7:0]   rd_v;
    logic         osc_run;
    logic         panel_on;
    geom_type     geom;
    int           num_errors = 0;
    int           compares = 0;

    always #10 MCLK = ~MCLK;

    lcdps_host u_lcdps_host (.MCLK(MCLK), .REQ(req), .RDATA(rdata));
    lcdps_regs u_lcdps_regs (.MCLK(MCLK), .RST(RST), .REQ(req), .RDATA(rdata),
                             .OSC_RUN(osc_run), .PANEL_ON(panel_on), .GEOM(geom));

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_lcdps_host.rd(a, rd_v);
        `CHK("rdata", e, rd_v)
    endtask

    task automatic complete_run;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        rchk(`OFF_POWER_SAVE, `RST_POWER_SAVE);
        `CHK("osc", 1'b0, osc_run)
        rchk(`OFF_FRAME_HEIGHT, 8'h00);
        u_lcdps_host.wr(1'b0, `OFF_POWER_SAVE, 8'h00);
        `CHK("osc", 1'b0, osc_run)
        u_lcdps_host.wr(1'b0, `OFF_FRAME_HEIGHT, 8'h3C);
        `CHK("osc", 1'b1, osc_run)
        rchk(`OFF_POWER_SAVE, 8'h00);
        u_lcdps_host.wr(1'b0, `OFF_HRANGE_LOW, 8'h34);
        u_lcdps_host.wr(1'b0, `OFF_HRANGE_HIGH, 8'h12);
        rchk(`OFF_HRANGE_LOW, 8'h34);
        rchk(`OFF_HRANGE_HIGH, 8'h12);
        `CHK("hrange", 16'h1234, geom.hrange)
        `CHK("height", 8'h3C, geom.frame_height)
        `CHK("panel", 1'b0, panel_on)
        u_lcdps_host.wr(1'b0, `OFF_DISPLAY_ONOFF, 8'h01);
        `CHK("panel", 1'b1, panel_on)
        u_lcdps_host.wr(1'b0, `OFF_POWER_SAVE, 8'h01);
        `CHK("osc", 1'b0, osc_run)
        `CHK("panel", 1'b0, panel_on)
        `CHK("disp_en", 1'b0, geom.disp_en)
        rchk(`OFF_DISPLAY_ONOFF, 8'h00);
        u_lcdps_host.wr(1'b1, 8'h00, `CMD_SYSTEM_SET);
        `CHK("osc", 1'b1, osc_run)
        `CHK("panel", 1'b0, panel_on)
        u_lcdps_host.wr(1'b0, `OFF_DISPLAY_ONOFF, 8'h01);
        u_lcdps_host.wr(1'b1, 8'h00, `CMD_POWER_DOWN);
        `CHK("osc", 1'b0, osc_run)
        `CHK("panel", 1'b0, panel_on)
        u_lcdps_host.wr(1'b0, 8'h20, 8'hFF);
        rchk(8'h20, 8'h00);
        complete_run;
    end

    initial begin
        repeat (500) @(posedge MCLK);
        num_errors++;
        complete_run;
    end
endmodule // tb_lcdps_regs
